// ### logic/incl_pkg.sv
// Shared constants and types for the L2 inclusion controller.
package incl_pkg;
    localparam int ADDR_W = 32;
    localparam int GRAN_BYTES = 32;
    localparam int LINE_BYTES = 64;
    localparam int SETS = 256;
    localparam int GRANS = LINE_BYTES / GRAN_BYTES;
    localparam int GRAN_W = (GRANS > 1) ? $clog2(GRANS) : 1;
    localparam int GOFF_W = $clog2(GRAN_BYTES);
    localparam int OFF_W = $clog2(LINE_BYTES);
    localparam int IDX_W = $clog2(SETS);
    localparam int TAG_W = ADDR_W - OFF_W - IDX_W;

    typedef enum logic [1:0]
    {
        MESI_INV = 2'b00,
        MESI_SHR = 2'b01,
        MESI_EXC = 2'b10,
        MESI_MOD = 2'b11
    } mesi_e;

    // Processor bus operations seen by the controller.
    typedef enum logic [2:0]
    {
        POP_READ = 3'b000,
        POP_READ_FOR_MODIFY = 3'b001,
        POP_WWK_DEALLOC = 3'b010,
        POP_KILL_DEALLOC = 3'b011,
        POP_ICACHE_INVAL = 3'b100
    } proc_op_e;

    // System bus snoop classes.
    typedef enum logic [1:0]
    {
        SOP_READ = 2'b00,
        SOP_READ_ATOMIC = 2'b01,
        SOP_OTHER = 2'b10
    } snp_op_e;

    typedef struct packed
    {
        logic [TAG_W-1:0] tag;
        mesi_e state;
        logic [GRANS-1:0] incl;
    } dir_entry_s;

    localparam dir_entry_s DIR_EMPTY = '{tag: '0, state: MESI_INV,
                                         incl: '0};
endpackage

// ### logic/dir_if.sv
// Directory access bundle between the control FSM and the tag store.
`timescale 1ns/10ps
interface dir_if;
    import incl_pkg::*;
    logic [IDX_W-1:0] rd_index;
    dir_entry_s rd_entry;
    logic wr_en;
    logic [IDX_W-1:0] wr_index;
    dir_entry_s wr_entry;

    modport ctl (output rd_index, input rd_entry, output wr_en,
                 output wr_index, output wr_entry);
    modport store (input rd_index, output rd_entry, input wr_en,
                   input wr_index, input wr_entry);
endinterface

// ### logic/dir_store.sv
// L2 tag, coherency state and inclusion bit store, one entry per set.
`timescale 1ns/10ps
module dir_store
    import incl_pkg::*;
#(
    parameter int DEPTH = SETS
)
(
    input wire logic sys_clk, // System clock.
    input wire logic resetn, // Synchronous reset, active low.
    dir_if.store dir // Read and write port.
);
    dir_entry_s mem [DEPTH];

    if (DEPTH != (1 << IDX_W))
    begin : g_chk
        $error("dir_store depth must equal the set count");
    end

    // Read is combinational so a lookup and its decision share a cycle.
    assign dir.rd_entry = mem[dir.rd_index];

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem[i] <= DIR_EMPTY;
            end
        end
        else if (dir.wr_en)
        begin
            mem[dir.wr_index] <= dir.wr_entry;
        end
    end
endmodule

// ### logic/l2_l1_inclusion_control.sv
// Inclusion maintenance control for an L2 cache in front of an L1.
`timescale 1ns/10ps
module l2_l1_inclusion_control
    import incl_pkg::*;
#(
    parameter bit RETRY_SHARED_OTHER = 1'b1,
    parameter bit THREE_STATE = 1'b0
)
(
    input wire logic sys_clk, // System clock, 125 MHz.
    input wire logic resetn, // Synchronous reset, active low.
    input wire logic marked_mode, // 1 marked inclusion, 0 simple.
    input wire logic proc_req_valid, // Processor bus operation present.
    input wire proc_op_e proc_req_op, // Processor bus operation kind.
    input wire logic [ADDR_W-1:0] proc_req_addr, // Operation address.
    output logic proc_req_ready, // Operation taken this cycle.
    output logic proc_ack, // Operation finished, one cycle.
    output logic binv_valid, // Back invalidation to processor.
    output logic [ADDR_W-1:0] binv_addr, // Granule address.
    input wire logic binv_resp_valid, // Snoop result of back invalidation.
    input wire logic binv_resp_hit, // Result was a hit.
    input wire logic push_done, // Snoop push-back has completed.
    output logic cb_valid, // Copy-back of old line to memory.
    output logic [ADDR_W-1:0] cb_addr, // Copy-back line address.
    input wire logic cb_ready, // Copy-back taken.
    output logic fetch_valid, // Fetch of new line from memory.
    output logic [ADDR_W-1:0] fetch_addr, // Fetch line address.
    input wire logic fetch_done, // Fetch has completed.
    input wire logic fetch_shared, // Line is shared by another cache.
    input wire logic snp_valid, // System bus snoop present.
    input wire snp_op_e snp_op, // Snoop operation class.
    input wire logic [ADDR_W-1:0] snp_addr, // Snoop address.
    output logic snp_ready, // Snoop taken this cycle.
    output logic snp_resp_valid, // Snoop answer, one cycle.
    output logic snp_retry, // Retry the system bus operation.
    output logic system_shared_response, // Assert shared on system bus.
    output logic snp_forward // Forward operation to processor.
);
    // ------------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_BINV = 3'b001,
        ST_PUSH = 3'b010,
        ST_COPYBACK = 3'b011,
        ST_FETCH = 3'b100
    } state_e;

    typedef struct packed
    {
        state_e st;
        logic [IDX_W-1:0] idx;
        logic [TAG_W-1:0] new_tag;
        logic [TAG_W-1:0] old_tag;
        logic [GRAN_W-1:0] acc_gran;
        logic rfm;
        logic [GRANS-1:0] pend;
        logic dirty;
        logic binv_valid;
        logic [ADDR_W-1:0] binv_addr;
        logic cb_valid;
        logic fetch_valid;
        logic proc_ack;
        logic snp_resp_valid;
        logic snp_retry;
        logic shared;
        logic forward;
    } ctl_s;

    localparam ctl_s CTL_RESET = '{st: ST_IDLE, rfm: 1'b0, dirty: 1'b0,
                                   binv_valid: 1'b0, cb_valid: 1'b0,
                                   fetch_valid: 1'b0, proc_ack: 1'b0,
                                   snp_resp_valid: 1'b0, snp_retry: 1'b0,
                                   shared: 1'b0, forward: 1'b0,
                                   default: '0};

    ctl_s q;
    ctl_s d;
    dir_if dir ();

    if ((LINE_BYTES % GRAN_BYTES) != 0 || GRANS < 2)
    begin : g_chk
        $error("line must hold two or more whole granules");
    end

    dir_store #(.DEPTH(SETS)) u_store
    (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .dir(dir)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [GRAN_W-1:0] first_set(
        input logic [GRANS-1:0] m);
        logic [GRAN_W-1:0] r;
        r = '0;
        for (int i = GRANS - 1; i >= 0; i--)
        begin
            if (m[i])
            begin
                r = GRAN_W'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [ADDR_W-1:0] gran_addr(
        input logic [TAG_W-1:0] t, input logic [IDX_W-1:0] i,
        input logic [GRAN_W-1:0] g);
        logic [ADDR_W-1:0] a;
        a = '0;
        a[ADDR_W-1 -: TAG_W] = t;
        a[OFF_W +: IDX_W] = i;
        a[GOFF_W +: GRAN_W] = g;
        return a;
    endfunction

    function automatic logic [ADDR_W-1:0] line_addr(
        input logic [TAG_W-1:0] t, input logic [IDX_W-1:0] i);
        return gran_addr(t, i, '0);
    endfunction

    // Address fields of the incoming requests.
    logic [TAG_W-1:0] snp_tag;
    logic [IDX_W-1:0] snp_idx;
    logic [GRAN_W-1:0] snp_gran;
    logic [TAG_W-1:0] req_tag;
    logic [IDX_W-1:0] req_idx;
    logic [GRAN_W-1:0] req_gran;
    logic take_snp;
    logic take_req;

    assign snp_tag = snp_addr[ADDR_W-1 -: TAG_W];
    assign snp_idx = snp_addr[OFF_W +: IDX_W];
    assign snp_gran = snp_addr[GOFF_W +: GRAN_W];
    assign req_tag = proc_req_addr[ADDR_W-1 -: TAG_W];
    assign req_idx = proc_req_addr[OFF_W +: IDX_W];
    assign req_gran = proc_req_addr[GOFF_W +: GRAN_W];

    // Snoops win the single directory port; both stall outside idle.
    assign snp_ready = (q.st == ST_IDLE);
    assign proc_req_ready = (q.st == ST_IDLE) && !snp_valid;
    assign take_snp = snp_valid && snp_ready;
    assign take_req = proc_req_valid && proc_req_ready;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        dir_entry_s e;
        dir_entry_s w;
        logic hit;
        logic [GRANS-1:0] left;
        e = dir.rd_entry;
        w = e;
        hit = 1'b0;
        left = '0;
        d = q;
        d.proc_ack = 1'b0;
        d.snp_resp_valid = 1'b0;
        dir.wr_en = 1'b0;
        dir.wr_index = q.idx;
        dir.rd_index = q.idx;
        if (q.st == ST_IDLE)
        begin
            dir.rd_index = snp_valid ? snp_idx : req_idx;
        end
        case (q.st)
            ST_IDLE:
            begin
                if (take_snp)
                begin
                    hit = (e.state != MESI_INV) && (e.tag == snp_tag);
                    d.snp_resp_valid = 1'b1;
                    d.snp_retry = 1'b0;
                    d.shared = 1'b0;
                    d.forward = 1'b0;
                    if (!hit)
                    begin
                        // No copy can be in the L1, answer clean.
                        d.forward = 1'b0;
                    end
                    else if (marked_mode && !e.incl[snp_gran])
                    begin
                        d.forward = 1'b0;
                    end
                    else if (e.state == MESI_SHR)
                    begin
                        // Set-bit hits fall through to the simple path.
                        if (snp_op != SOP_OTHER)
                        begin
                            d.shared = 1'b1;
                        end
                        else
                        begin
                            d.snp_retry = RETRY_SHARED_OTHER;
                            d.forward = RETRY_SHARED_OTHER;
                        end
                    end
                    else
                    begin
                        d.snp_retry = 1'b1;
                        d.forward = 1'b1;
                    end
                end
                else if (take_req)
                begin
                    d.idx = req_idx;
                    d.new_tag = req_tag;
                    d.acc_gran = req_gran;
                    d.rfm = (proc_req_op == POP_READ_FOR_MODIFY);
                    hit = (e.state != MESI_INV) && (e.tag == req_tag);
                    dir.wr_index = req_idx;
                    case (proc_req_op)
                        POP_READ, POP_READ_FOR_MODIFY:
                        begin
                            if (hit && (!d.rfm || e.state != MESI_SHR))
                            begin
                                w.incl[req_gran] = 1'b1;
                                dir.wr_en = 1'b1;
                                d.proc_ack = 1'b1;
                            end
                            else if (hit)
                            begin
                                // Ownership upgrade keeps the tag.
                                w.incl[req_gran] = 1'b1;
                                dir.wr_en = 1'b1;
                                d.pend = '0;
                                d.dirty = 1'b0;
                                d.old_tag = e.tag;
                                d.fetch_valid = 1'b1;
                                d.st = ST_FETCH;
                            end
                            else
                            begin
                                // Victim: all granules in simple mode,
                                // only the included ones when marked.
                                d.old_tag = e.tag;
                                d.dirty = (e.state == MESI_MOD);
                                if (e.state == MESI_INV)
                                begin
                                    d.pend = '0;
                                end
                                else if (marked_mode)
                                begin
                                    d.pend = e.incl;
                                end
                                else
                                begin
                                    d.pend = '1;
                                end
                                if (d.pend != '0)
                                begin
                                    d.binv_addr = gran_addr(e.tag, req_idx,
                                        first_set(d.pend));
                                    d.binv_valid = 1'b1;
                                    d.st = ST_BINV;
                                end
                                else if (d.dirty)
                                begin
                                    d.cb_valid = 1'b1;
                                    d.st = ST_COPYBACK;
                                end
                                else
                                begin
                                    d.fetch_valid = 1'b1;
                                    d.st = ST_FETCH;
                                end
                            end
                        end
                        POP_WWK_DEALLOC, POP_KILL_DEALLOC, POP_ICACHE_INVAL:
                        begin
                            if (hit)
                            begin
                                w.incl[req_gran] = 1'b0;
                                if (proc_req_op == POP_WWK_DEALLOC)
                                begin
                                    // A castout lands modified data here.
                                    w.state = MESI_MOD;
                                end
                                dir.wr_en = 1'b1;
                            end
                            d.proc_ack = 1'b1;
                        end
                        default:
                        begin
                            // Reads that replace L1 lines implicitly are
                            // not seen, so bits stay set.
                            d.proc_ack = 1'b1;
                        end
                    endcase
                end
            end
            ST_BINV:
            begin
                // One outstanding back invalidation at a time.
                if (binv_resp_valid)
                begin
                    d.binv_valid = 1'b0;
                    if (binv_resp_hit)
                    begin
                        d.st = ST_PUSH;
                    end
                    else
                    begin
                        // Granule already left the L1.
                        d.pend[first_set(q.pend)] = 1'b0;
                    end
                end
            end
            ST_PUSH:
            begin
                if (push_done)
                begin
                    d.pend[first_set(q.pend)] = 1'b0;
                end
            end
            ST_COPYBACK:
            begin
                if (cb_ready)
                begin
                    d.cb_valid = 1'b0;
                    d.dirty = 1'b0;
                    d.fetch_valid = 1'b1;
                    d.st = ST_FETCH;
                end
            end
            ST_FETCH:
            begin
                if (fetch_done)
                begin
                    d.fetch_valid = 1'b0;
                    // An upgrade keeps its other bits: those granules
                    // may still sit in the L1.
                    if (e.state == MESI_INV || e.tag != q.new_tag)
                    begin
                        w.incl = '0;
                    end
                    w.tag = q.new_tag;
                    w.incl[q.acc_gran] = 1'b1;
                    if (q.rfm || (!fetch_shared && !THREE_STATE))
                    begin
                        w.state = MESI_EXC;
                    end
                    else
                    begin
                        w.state = MESI_SHR;
                    end
                    dir.wr_en = 1'b1;
                    d.proc_ack = 1'b1;
                    d.st = ST_IDLE;
                end
            end
            default:
            begin
                d = CTL_RESET;
            end
        endcase
        // Leaving the push-back states once every granule is done.
        if ((q.st == ST_BINV || q.st == ST_PUSH) &&
            (d.st != ST_IDLE) && !d.binv_valid &&
            (d.st == ST_BINV || push_done))
        begin
            left = d.pend;
            if (left != '0)
            begin
                d.binv_addr = gran_addr(q.old_tag, q.idx, first_set(left));
                d.binv_valid = 1'b1;
                d.st = ST_BINV;
            end
            else if (q.dirty)
            begin
                d.cb_valid = 1'b1;
                d.st = ST_COPYBACK;
            end
            else
            begin
                d.fetch_valid = 1'b1;
                d.st = ST_FETCH;
            end
        end
        // The old tag of a replaced line is removed on entry to the fetch, never earlier,
        // and no L1 copy-back buffer tracking is needed.
        if (d.st == ST_FETCH && q.st != ST_FETCH && !dir.wr_en)
        begin
            w = DIR_EMPTY;
            dir.wr_index = d.idx;
            dir.wr_en = 1'b1;
        end
        dir.wr_entry = w;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            q <= CTL_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign proc_ack = q.proc_ack;
    assign binv_valid = q.binv_valid;
    assign binv_addr = q.binv_addr;
    assign cb_valid = q.cb_valid;
    assign cb_addr = line_addr(q.old_tag, q.idx);
    assign fetch_valid = q.fetch_valid;
    assign fetch_addr = line_addr(q.new_tag, q.idx);
    assign snp_resp_valid = q.snp_resp_valid;
    assign snp_retry = q.snp_retry && q.snp_resp_valid;
    assign system_shared_response = q.shared && q.snp_resp_valid;
    assign snp_forward = q.forward && q.snp_resp_valid;
endmodule

// ### dv/incl_props.sv
// Port-level checks for the inclusion controller.
`timescale 1ns/10ps
module incl_props
    import incl_pkg::*;
(
    input wire logic sys_clk, // Clock.
    input wire logic resetn, // Reset.
    input wire logic proc_req_ready, // Out.
    input wire logic snp_valid, // In.
    input wire logic snp_ready, // Out.
    input wire logic snp_resp_valid, // Out.
    input wire logic snp_retry, // Out.
    input wire logic system_shared_response, // Out.
    input wire logic snp_forward, // Out.
    input wire logic binv_valid, // Out.
    input wire logic [ADDR_W-1:0] binv_addr, // Out.
    input wire logic binv_resp_valid, // In.
    input wire logic binv_resp_hit, // In.
    input wire logic cb_valid, // Out.
    input wire logic fetch_valid, // Out.
    input wire logic [ADDR_W-1:0] fetch_addr, // Out.
    input wire logic fetch_done // In.
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    a_snoop_answer:
        assert property (snp_valid && snp_ready |=> snp_resp_valid)
        else $error("snoop answer missing");
    a_quiet_idle:
        assert property (!snp_resp_valid |-> !(snp_retry
            || system_shared_response || snp_forward))
        else $error("snoop outputs outside answer");
    a_retry_forward:
        assert property (snp_resp_valid |-> snp_retry == snp_forward)
        else $error("retry without forward");
    a_shared_only:
        assert property (system_shared_response |-> !snp_retry)
        else $error("shared with retry");
    a_binv_hold:
        assert property (binv_valid && !binv_resp_valid
            |=> binv_valid && $stable(binv_addr))
        else $error("back invalidation dropped");
    a_push_wait:
        assert property (binv_resp_valid && binv_resp_hit
            |=> !binv_valid && !fetch_valid)
        else $error("moved on before push-back");
    a_binv_first:
        assert property (binv_valid |-> !cb_valid && !fetch_valid)
        else $error("memory access during back invalidation");
    a_fetch_hold:
        assert property (fetch_valid && !fetch_done
            |=> fetch_valid && $stable(fetch_addr))
        else $error("fetch dropped");
    a_busy_refuse:
        assert property (binv_valid || cb_valid || fetch_valid
            |-> !proc_req_ready && !snp_ready)
        else $error("request taken during replacement");
endmodule
bind l2_l1_inclusion_control incl_props i_incl_props (.sys_clk, .resetn,
    .proc_req_ready, .snp_valid, .snp_ready, .snp_resp_valid, .snp_retry,
    .system_shared_response, .snp_forward, .binv_valid, .binv_addr,
    .binv_resp_valid, .binv_resp_hit, .cb_valid, .fetch_valid,
    .fetch_addr, .fetch_done);

// ### dv/far_model.sv
// L1 snoop and memory responder facing the inclusion controller.
`timescale 1ns/10ps
module far_model
    import incl_pkg::*;
(
    input wire logic sys_clk, // Clock.
    input wire logic slow, // Random answer delay.
    input wire logic shr, // Fetch comes back shared.
    input wire logic binv_valid, // Back invalidation.
    input wire logic [ADDR_W-1:0] binv_addr, // Granule.
    output logic binv_resp_valid = 1'b0, // Result pulse.
    output logic binv_resp_hit = 1'b0, // Hit.
    output logic push_done = 1'b0, // Push-back done.
    input wire logic cb_valid, // Copy-back.
    output logic cb_ready = 1'b0, // Copy-back taken.
    input wire logic fetch_valid, // Fetch.
    output logic fetch_done = 1'b0, // Fetch done.
    output logic fetch_shared = 1'b0 // Shared flag.
);
    bit l1[logic [ADDR_W-1:0]];
    bit pend = 1'b0;
    int dly = 0;
    task automatic l1_add(input logic [ADDR_W-1:0] a);
        l1[a] = 1'b1;
    endtask
    always @(posedge sys_clk)
    begin
        {binv_resp_valid, push_done, cb_ready, fetch_done} <= 4'h0;
        // Qualifiers toggle when idle so a stale value is never trusted.
        binv_resp_hit <= ~binv_resp_hit;
        fetch_shared <= (fetch_valid && !fetch_done) ? shr : ~fetch_shared;
        if (dly > 0)
            dly <= dly - 1;
        else
        begin
            dly <= slow ? $urandom_range(3) : 0;
            push_done <= pend;
            pend <= 1'b0;
            cb_ready <= cb_valid && !cb_ready;
            fetch_done <= fetch_valid && !fetch_done;
            if (binv_valid && !binv_resp_valid)
            begin
                binv_resp_valid <= 1'b1;
                binv_resp_hit <= l1.exists(binv_addr) != 0;
                pend <= l1.exists(binv_addr) != 0;
                l1.delete(binv_addr);
            end
        end
    end
endmodule

// ### dv/l2_l1_inclusion_control_tb.sv
// Self-checking bench for the L2 inclusion controller.
`timescale 1ns/10ps
module l2_l1_inclusion_control_tb;
    import incl_pkg::*;
    logic sys_clk = 1'b0, resetn = 1'b0, marked_mode = 1'b0;
    logic slow = 1'b0, shr = 1'b0, proc_req_valid = 1'b0, snp_valid = 1'b0;
    proc_op_e proc_req_op = POP_READ;
    snp_op_e snp_op = SOP_READ;
    logic [ADDR_W-1:0] proc_req_addr = '0, snp_addr = '0;
    logic [ADDR_W-1:0] binv_addr, cb_addr, fetch_addr;
    logic proc_req_ready, proc_ack, binv_valid, binv_resp_valid;
    logic binv_resp_hit, push_done, cb_valid, cb_ready, fetch_valid;
    logic fetch_done, fetch_shared, snp_ready, snp_resp_valid, snp_retry;
    logic system_shared_response, snp_forward;
    logic [ADDR_W-1:0] bus_q[$];
    logic [2:0] snp_q[$];
    int n_errors = 0, n_tests = 0, tg[256];
    bit vld[256];
    always #4 sys_clk = ~sys_clk;
    l2_l1_inclusion_control i_l2_l1_inclusion_control (.*);
    far_model i_far_model (.*);
    function automatic logic [ADDR_W-1:0] ad(int t, int i, int g);
        return {t[TAG_W-1:0], i[IDX_W-1:0], g[0], 5'h00};
    endfunction
    task automatic chk(string nm, logic [ADDR_W-1:0] e, logic [ADDR_W-1:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic preq(proc_op_e op, logic [ADDR_W-1:0] a);
        @(negedge sys_clk);
        proc_req_valid = 1'b1;
        proc_req_op = op;
        proc_req_addr = a;
        while (!proc_req_ready)
            @(negedge sys_clk);
        @(negedge sys_clk);
        proc_req_valid = 1'b0;
        for (int k = 0; k < 300 && proc_ack !== 1'b1; k++)
            @(negedge sys_clk);
        chk("ack", 32'h0000_0001, ADDR_W'(proc_ack));
    endtask
    task automatic snp(snp_op_e op, logic [ADDR_W-1:0] a, logic [2:0] e);
        @(negedge sys_clk);
        snp_valid = 1'b1;
        snp_op = op;
        snp_addr = a;
        snp_q.push_back(e);
        @(negedge sys_clk);
        snp_valid = 1'b0;
    endtask
    // Simple mode miss: every granule of a valid victim is invalidated.
    task automatic rd_miss(int t, int i, int g);
        if (vld[i])
        begin
            bus_q.push_back(ad(tg[i], i, 0));
            bus_q.push_back(ad(tg[i], i, 1));
        end
        bus_q.push_back(ad(t, i, 0));
        vld[i] = 1'b1;
        tg[i] = t;
        i_far_model.l1_add(ad(t, i, g));
        preq(POP_READ, ad(t, i, g));
    endtask
    always @(posedge sys_clk)
    begin
        if (binv_valid && binv_resp_valid)
            chk("binv", bus_q.pop_front(), binv_addr);
        if (cb_valid && cb_ready)
            chk("cb", bus_q.pop_front(), cb_addr);
        if (fetch_valid && fetch_done)
            chk("fetch", bus_q.pop_front(), fetch_addr);
        if (snp_resp_valid)
            chk("snp", ADDR_W'(snp_q.pop_front()), ADDR_W'({snp_retry,
                system_shared_response, snp_forward}));
    end
    // The tests need a few hundred cycles; this bound of 12500 cycles is far beyond that.
    initial
    begin
        #100000;
        n_errors++;
        print_verdict;
    end
    initial
    begin
        int i;
        void'($urandom(82));
        repeat (3) @(negedge sys_clk);
        resetn = 1'b1;
        rd_miss(1, 5, 0);
        snp(SOP_READ, ad(1, 5, 0), 3'b101);
        snp(SOP_OTHER, ad(9, 5, 0), 3'b000);
        $display("test 1 done");
        shr = 1'b1;
        rd_miss(2, 5, 1);
        snp(SOP_READ, ad(2, 5, 1), 3'b010);
        snp(SOP_READ_ATOMIC, ad(2, 5, 0), 3'b010);
        snp(SOP_OTHER, ad(2, 5, 1), 3'b101);
        $display("test 2 done");
        for (int j = 0; j < 16; j++)
        begin
            slow = 1'($urandom_range(1));
            shr = 1'($urandom_range(1));
            i = $urandom_range(16, 40);
            rd_miss(tg[i] + 1 + $urandom_range(9), i, $urandom_range(1));
        end
        $display("test 3 done");
        {marked_mode, slow, shr} = 3'b100;
        preq(POP_WWK_DEALLOC, ad(2, 5, 1));
        snp(SOP_READ, ad(2, 5, 1), 3'b000);
        snp(SOP_OTHER, ad(7, 5, 0), 3'b000);
        bus_q.push_back(ad(2, 5, 0));
        bus_q.push_back(ad(3, 5, 0));
        preq(POP_READ, ad(3, 5, 0));
        preq(POP_READ, ad(3, 5, 1));
        i_far_model.l1_add(ad(3, 5, 1));
        snp(SOP_READ, ad(3, 5, 1), 3'b101);
        preq(POP_ICACHE_INVAL, ad(3, 5, 0));
        snp(SOP_READ, ad(3, 5, 0), 3'b000);
        bus_q.push_back(ad(3, 5, 1));
        bus_q.push_back(ad(4, 5, 0));
        preq(POP_READ, ad(4, 5, 1));
        preq(POP_KILL_DEALLOC, ad(4, 5, 1));
        preq(POP_READ_FOR_MODIFY, ad(4, 5, 0));
        snp(SOP_OTHER, ad(4, 5, 0), 3'b101);
        snp(SOP_READ, ad(4, 5, 1), 3'b000);
        // Ownership upgrade of a shared line must keep both bits.
        shr = 1'b1;
        bus_q.push_back(ad(6, 9, 0));
        bus_q.push_back(ad(6, 9, 0));
        preq(POP_READ, ad(6, 9, 0));
        preq(POP_READ, ad(6, 9, 1));
        preq(POP_READ_FOR_MODIFY, ad(6, 9, 1));
        snp(SOP_READ, ad(6, 9, 0), 3'b101);
        repeat (3) @(negedge sys_clk);
        chk("left", '0, ADDR_W'(bus_q.size() + snp_q.size()));
        $display("test 4 done");
        print_verdict;
    end
endmodule
